// *** src/lfc_loop_filter_coeff.sv ***
// Function
// - alpha gain is mantissa times two to minus sixteen minus shift plus both gains.
// - alpha shift moves the binary point left; software keeps it within 0 to 63.
// - beta and gamma are stored as magnitudes and negated inside the datapath.
// - beta magnitude is mantissa times two to minus seventeen plus exponent.
// - gamma is mantissa times two to minus seventeen plus exponent, same limits.
// - delta is mantissa times two to minus fifteen plus exponent, mantissa to 32,767.
// - feedback divide ratio is stored integer plus one plus numerator over denominator.
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "lfc_consts.svh"

module lfc_loop_filter_coeff (
    input  wire logic               clk_i,
    input  wire logic               rst_n_i,
    input  wire logic               psel_i,
    input  wire logic               penable_i,
    input  wire logic               pwrite_i,
    input  wire logic        [7:0]  paddr_i,
    input  wire logic        [31:0] pwdata_i,
    output logic             [31:0] prdata_o,
    output logic                    pready_o,
    output logic                    pslverr_o,
    input  wire logic               upd_i,
    input  wire logic signed [23:0] err_i,
    output logic signed      [31:0] alpha_term_o,
    output logic signed      [31:0] beta_term_o,
    output logic signed      [31:0] gamma_term_o,
    output logic signed      [31:0] delta_term_o,
    output logic signed      [31:0] filt_o,
    output logic                    valid_o,
    output logic                    prof_o,
    output logic             [30:0] div_int_o,
    output logic             [9:0]  div_num_o,
    output logic             [9:0]  div_den_o
);

    logic        [31:0] coef_q [2][6];
    logic        [31:0] coef_d [2][6];
    logic               sel_q;
    logic               sel_d;
    logic               clr_q;
    logic               clr_d;
    logic        [15:0] cnt_q;
    logic        [15:0] cnt_d;
    logic signed [31:0] integ_q;
    logic signed [31:0] integ_d;
    logic        [31:0] prdata_d;
    logic               pready_d;
    logic               pslverr_d;
    logic signed [31:0] alpha_d;
    logic signed [31:0] beta_d;
    logic signed [31:0] gamma_d;
    logic signed [31:0] delta_d;
    logic signed [31:0] filt_d;
    logic               valid_d;
    logic               prof_d;
    logic        [30:0] div_int_d;
    logic        [9:0]  div_num_d;
    logic        [9:0]  div_den_d;

    logic               setup;
    logic               wr_en;
    logic               hit_reg;
    logic               hit_ctrl;
    logic               hit_ro;
    logic        [31:0] ro_data;
    logic               pa;
    logic        [2:0]  ra;

    logic        [15:0] a_mant;
    logic        [5:0]  a_shift;
    logic        [2:0]  a_fe;
    logic        [3:0]  a_be;
    logic        [16:0] b_mant;
    logic        [4:0]  b_exp;
    logic        [16:0] g_mant;
    logic        [4:0]  g_exp;
    logic        [14:0] d_mant;
    logic        [4:0]  d_exp;
    logic        [29:0] div_s;
    logic signed [31:0] a_mul;
    logic signed [31:0] b_mul;
    logic signed [31:0] g_mul;
    logic signed [31:0] d_mul;

    function automatic logic [31:0] field_mask(input logic [2:0] idx);
        logic [31:0] m;
        m = `LFC_MASK_DIVUV;
        if (idx == `LFC_IDX_ALPHA) begin
            m = `LFC_MASK_ALPHA;
        end else if (idx == `LFC_IDX_BETA || idx == `LFC_IDX_GAMMA) begin
            m = `LFC_MASK_BG;
        end else if (idx == `LFC_IDX_DELTA) begin
            m = `LFC_MASK_DELTA;
        end else if (idx == `LFC_IDX_DIVS) begin
            m = `LFC_MASK_DIVS;
        end
        return m;
    endfunction

    // ---- apb slave: one wait-free access phase, pready registered in the setup cycle
    assign setup = psel_i & ~penable_i;
    assign wr_en = psel_i & penable_i & pready_o & pwrite_i;
    assign pa    = paddr_i[`LFC_PROF_BIT];
    assign ra    = paddr_i[4:2];

    always_comb begin
        hit_reg  = 1'b0;
        hit_ctrl = 1'b0;
        hit_ro   = 1'b1;
        ro_data  = 32'h0000_0000;
        if (paddr_i[7:6] == 2'h0 && paddr_i[1:0] == 2'h0 && ra < `LFC_NUM_REGS) begin
            hit_reg = 1'b1;
            hit_ro  = 1'b0;
        end else if (paddr_i == `LFC_OFF_CTRL) begin
            hit_ctrl = 1'b1;
            hit_ro   = 1'b0;
            ro_data  = {31'h0, sel_q};
        end else if (paddr_i == `LFC_OFF_STAT) begin
            ro_data = {cnt_q, 15'h0, prof_o};
        end else if (paddr_i == `LFC_OFF_TALPHA) begin
            ro_data = alpha_term_o;
        end else if (paddr_i == `LFC_OFF_TBETA) begin
            ro_data = beta_term_o;
        end else if (paddr_i == `LFC_OFF_TGAMMA) begin
            ro_data = gamma_term_o;
        end else if (paddr_i == `LFC_OFF_TDELTA) begin
            ro_data = delta_term_o;
        end else if (paddr_i == `LFC_OFF_FILT) begin
            ro_data = integ_q;
        end else begin
            hit_ro = 1'b0;
        end
    end

    always_comb begin
        coef_d    = coef_q;
        sel_d     = sel_q;
        clr_d     = 1'b0;
        pready_d  = setup;
        pslverr_d = setup & ~(hit_reg | hit_ctrl | hit_ro);
        prdata_d  = 32'h0000_0000;
        if (wr_en && hit_reg) begin
            // only field bits are stored, so reserved bits always read zero
            coef_d[pa][ra] = pwdata_i & field_mask(ra);
        end else if (wr_en && hit_ctrl) begin
            sel_d = pwdata_i[`LFC_CTRL_SEL];
            clr_d = pwdata_i[`LFC_CTRL_CLR];
        end
        if (setup && !pwrite_i && hit_reg) begin
            prdata_d = coef_q[pa][ra];
        end else if (setup && !pwrite_i) begin
            prdata_d = ro_data;
        end
    end

    // ---- field decode of the currently selected profile
    always_comb begin
        a_mant  = coef_q[sel_q][`LFC_IDX_ALPHA][`LFC_A_MANT];
        a_shift = coef_q[sel_q][`LFC_IDX_ALPHA][`LFC_A_SHIFT];
        a_fe    = coef_q[sel_q][`LFC_IDX_ALPHA][`LFC_A_FE];
        a_be    = coef_q[sel_q][`LFC_IDX_ALPHA][`LFC_A_BE];
        b_mant  = coef_q[sel_q][`LFC_IDX_BETA][`LFC_BG_MANT];
        b_exp   = coef_q[sel_q][`LFC_IDX_BETA][`LFC_BG_EXP];
        g_mant  = coef_q[sel_q][`LFC_IDX_GAMMA][`LFC_BG_MANT];
        g_exp   = coef_q[sel_q][`LFC_IDX_GAMMA][`LFC_BG_EXP];
        d_mant  = coef_q[sel_q][`LFC_IDX_DELTA][`LFC_D_MANT];
        d_exp   = coef_q[sel_q][`LFC_IDX_DELTA][`LFC_D_EXP];
        div_s   = coef_q[sel_q][`LFC_IDX_DIVS][`LFC_DIV_S];
    end

    lfc_coef_mul u_alpha (
        .kind_i (lfc_pkg::LFC_ALPHA),
        .err_i  (err_i),
        .mant_i ({1'b0, a_mant}),
        .exp_i  (a_shift),
        .gain_i (5'({2'h0, a_fe}) + 5'({1'h0, a_be})),
        .term_o (a_mul)
    );
    lfc_coef_mul u_beta (
        .kind_i (lfc_pkg::LFC_BETA),
        .err_i  (err_i),
        .mant_i (b_mant),
        .exp_i  ({1'b0, b_exp}),
        .gain_i (5'h00),
        .term_o (b_mul)
    );
    lfc_coef_mul u_gamma (
        .kind_i (lfc_pkg::LFC_GAMMA),
        .err_i  (err_i),
        .mant_i (g_mant),
        .exp_i  ({1'b0, g_exp}),
        .gain_i (5'h00),
        .term_o (g_mul)
    );
    lfc_coef_mul u_delta (
        .kind_i (lfc_pkg::LFC_DELTA),
        .err_i  (err_i),
        .mant_i ({2'b0, d_mant}),
        .exp_i  ({1'b0, d_exp}),
        .gain_i (5'h00),
        .term_o (d_mul)
    );

    // ---- filter update: all terms and the integrator move together on upd_i
    always_comb begin
        alpha_d   = alpha_term_o;
        beta_d    = beta_term_o;
        gamma_d   = gamma_term_o;
        delta_d   = delta_term_o;
        filt_d    = filt_o;
        prof_d    = prof_o;
        cnt_d     = cnt_q;
        integ_d   = clr_q ? 32'sh0000_0000 : integ_q;
        valid_d   = upd_i;
        if (upd_i) begin
            alpha_d = a_mul;
            beta_d  = b_mul;
            gamma_d = g_mul;
            delta_d = d_mul;
            prof_d  = sel_q;
            cnt_d   = cnt_q + 16'h0001;
            // a clear in the same cycle still keeps this update's contribution
            integ_d = lfc_pkg::lfc_sat32(64'(integ_d) + 64'(g_mul));
            filt_d  = lfc_pkg::lfc_sat32(64'(a_mul) + 64'(b_mul) + 64'(integ_d)
                                         + 64'(d_mul));
        end
        div_int_d = 31'(div_s) + 31'h0000_0001;
        div_num_d = coef_q[sel_q][`LFC_IDX_DIVUV][`LFC_DIV_U];
        div_den_d = coef_q[sel_q][`LFC_IDX_DIVUV][`LFC_DIV_V];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int p = 0; p < 2; p++) begin
                for (int r = 0; r < 6; r++) begin
                    coef_q[p][r] <= `LFC_RST_COEF;
                end
            end
            sel_q        <= `LFC_RST_CTRL;
            clr_q        <= 1'b0;
            cnt_q        <= 16'h0000;
            integ_q      <= 32'sh0000_0000;
            prdata_o     <= 32'h0000_0000;
            pready_o     <= 1'b0;
            pslverr_o    <= 1'b0;
            alpha_term_o <= 32'sh0000_0000;
            beta_term_o  <= 32'sh0000_0000;
            gamma_term_o <= 32'sh0000_0000;
            delta_term_o <= 32'sh0000_0000;
            filt_o       <= 32'sh0000_0000;
            valid_o      <= 1'b0;
            prof_o       <= 1'b0;
            div_int_o    <= 31'h0000_0001;
            div_num_o    <= 10'h000;
            div_den_o    <= 10'h000;
        end else begin
            coef_q       <= coef_d;
            sel_q        <= sel_d;
            clr_q        <= clr_d;
            cnt_q        <= cnt_d;
            integ_q      <= integ_d;
            prdata_o     <= prdata_d;
            pready_o     <= pready_d;
            pslverr_o    <= pslverr_d;
            alpha_term_o <= alpha_d;
            beta_term_o  <= beta_d;
            gamma_term_o <= gamma_d;
            delta_term_o <= delta_d;
            filt_o       <= filt_d;
            valid_o      <= valid_d;
            prof_o       <= prof_d;
            div_int_o    <= div_int_d;
            div_num_o    <= div_num_d;
            div_den_o    <= div_den_d;
        end
    end

    // ---- checks
    logic signed [40:0] chk_pa;
    logic signed [41:0] chk_pb;
    logic signed [39:0] chk_pd;
    assign chk_pa = err_i * $signed({1'b0, a_mant});
    assign chk_pb = err_i * $signed({1'b0, b_mant});
    assign chk_pd = err_i * $signed({1'b0, d_mant});
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_n_i);
    property p_ready;
        setup |=> pready_o ##1 !pready_o;
    endproperty
    a_ready: assert property (p_ready) else $error("pready not a single cycle after setup");
    property p_unmapped;
        setup && !(hit_reg || hit_ctrl || hit_ro) |=> pslverr_o && pready_o;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access without pslverr");
    // gain 8 is the smallest split that software can load into both gain fields
    property p_alpha_gain;
        upd_i && a_shift == 6'h00 && a_fe == 3'h7 && a_be == 4'h1
            |=> alpha_term_o == 32'($past(chk_pa) >>> 8);
    endproperty
    a_alpha_gain: assert property (p_alpha_gain) else $error("alpha gains misapplied");
    property p_alpha_shift;
        upd_i && a_shift == 6'h06 && a_fe == 3'h0 && a_be == 4'h0
            |=> alpha_term_o == 32'($past(chk_pa) >>> 22);
    endproperty
    a_alpha_shift: assert property (p_alpha_shift) else $error("alpha shift misapplied");
    property p_beta;
        upd_i && b_exp == 5'h00 |=> beta_term_o == -(32'($past(chk_pb) >>> 17));
    endproperty
    a_beta: assert property (p_beta) else $error("beta term wrong");
    property p_gamma_neg;
        upd_i && g_exp == 5'h00 && g_mant != 17'h0 && err_i >= 24'sh02_0000
            |=> gamma_term_o < 0 ##1 (valid_o || gamma_term_o < 0);
    endproperty
    a_gamma_neg: assert property (p_gamma_neg) else $error("gamma not negated");
    property p_delta;
        upd_i && d_exp == 5'h00 |=> delta_term_o == 32'($past(chk_pd) >>> 15);
    endproperty
    a_delta: assert property (p_delta) else $error("delta term wrong");
    property p_div;
        ##1 $stable(div_s) |=> div_int_o == 31'($past(div_s, 2)) + 31'h0000_0001;
    endproperty
    a_div: assert property (p_div) else $error("divide ratio not stored plus one");
    property p_prof;
        upd_i |=> valid_o && prof_o == $past(sel_q);
    endproperty
    a_prof: assert property (p_prof) else $error("update used wrong profile");

endmodule

`default_nettype wire

// *** src/lfc_consts.svh ***
`ifndef LFC_CONSTS_SVH
`define LFC_CONSTS_SVH

// register indices inside one profile, byte address = profile base + 4 * index
`define LFC_NUM_REGS    3'h6
`define LFC_IDX_ALPHA   3'h0
`define LFC_IDX_BETA    3'h1
`define LFC_IDX_GAMMA   3'h2
`define LFC_IDX_DELTA   3'h3
`define LFC_IDX_DIVS    3'h4
`define LFC_IDX_DIVUV   3'h5

// profile 0 at 0x00, profile 1 at 0x20
`define LFC_PROF_BIT    5
`define LFC_OFF_CTRL    8'h40
`define LFC_OFF_STAT    8'h44
`define LFC_OFF_TALPHA  8'h48
`define LFC_OFF_TBETA   8'h4C
`define LFC_OFF_TGAMMA  8'h50
`define LFC_OFF_TDELTA  8'h54
`define LFC_OFF_FILT    8'h58

// writable field masks
`define LFC_MASK_ALPHA  32'h1FFF_FFFF
`define LFC_MASK_BG     32'h003F_FFFF
`define LFC_MASK_DELTA  32'h000F_FFFF
`define LFC_MASK_DIVS   32'h3FFF_FFFF
`define LFC_MASK_DIVUV  32'h000F_FFFF

// field positions
`define LFC_A_MANT      15:0
`define LFC_A_SHIFT     21:16
`define LFC_A_FE        24:22
`define LFC_A_BE        28:25
`define LFC_BG_MANT     16:0
`define LFC_BG_EXP      21:17
`define LFC_D_MANT      14:0
`define LFC_D_EXP       19:15
`define LFC_DIV_S       29:0
`define LFC_DIV_U       9:0
`define LFC_DIV_V       19:10
`define LFC_CTRL_SEL    0
`define LFC_CTRL_CLR    1
`define LFC_STAT_CNT    31:16

// reset values
`define LFC_RST_COEF    32'h0000_0000
`define LFC_RST_CTRL    1'h0

// fixed binary point of each mantissa
`define LFC_BASE_ALPHA  7'h10
`define LFC_BASE_BETA   7'h11
`define LFC_BASE_GAMMA  7'h11
`define LFC_BASE_DELTA  7'h0F

`endif

// *** src/lfc_pkg.sv ***
package lfc_pkg;

    typedef enum logic [1:0] {
        LFC_ALPHA = 2'b00,
        LFC_BETA  = 2'b01,
        LFC_GAMMA = 2'b10,
        LFC_DELTA = 2'b11
    } lfc_coef_t;

    typedef logic signed [31:0] lfc_term_t;

    function automatic lfc_term_t lfc_sat32(input logic signed [63:0] v);
        lfc_term_t r;
        if (v > 64'sh0000_0000_7FFF_FFFF) begin
            r = 32'sh7FFF_FFFF;
        end else if (v < -64'sh0000_0000_8000_0000) begin
            r = 32'sh8000_0000;
        end else begin
            r = v[31:0];
        end
        return r;
    endfunction

endpackage

// *** src/lfc_coef_mul.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "lfc_consts.svh"

module lfc_coef_mul (
    input  wire lfc_pkg::lfc_coef_t  kind_i,
    input  wire logic signed [23:0]  err_i,
    input  wire logic        [16:0]  mant_i,
    input  wire logic        [5:0]   exp_i,
    input  wire logic        [4:0]   gain_i,
    output var  lfc_pkg::lfc_term_t  term_o
);

    logic        [6:0]  rsh;
    logic               neg;
    logic signed [41:0] prod;
    logic signed [63:0] wide;

    always_comb begin
        case (kind_i)
            lfc_pkg::LFC_ALPHA: rsh = `LFC_BASE_ALPHA;
            lfc_pkg::LFC_BETA:  rsh = `LFC_BASE_BETA;
            lfc_pkg::LFC_GAMMA: rsh = `LFC_BASE_GAMMA;
            default:            rsh = `LFC_BASE_DELTA;
        endcase
        rsh  = rsh + {1'b0, exp_i};
        // stored magnitudes of beta and gamma are applied negated
        neg  = (kind_i == lfc_pkg::LFC_BETA) || (kind_i == lfc_pkg::LFC_GAMMA);
        prod = err_i * $signed({1'b0, mant_i});
        // gain is applied before the right shift so no fraction bits are lost
        wide = (64'(prod) <<< gain_i) >>> rsh;
        if (neg) begin
            wide = -wide;
        end
        term_o = lfc_pkg::lfc_sat32(wide);
    end

endmodule

`default_nettype wire

// *** tb/lfc_host.sv ***
`timescale 1ns/10ps
`default_nettype none

module lfc_host (
    input  wire logic        clk_i,
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic [7:0]       paddr_o,
    output logic [31:0]      pwdata_o
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0000_0000;
    end

    // no wait count is assumed: the request stands until pready is seen at an edge
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) begin
            @(posedge clk_i);
        end
        rd = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask

    // loop gain scale at the 20 MHz system clock; it drives the largest alpha gain request
    function automatic real scale_k();
        return 20.0e6 * 30517578125.0 / (2.0 ** 33);
    endfunction

    function automatic int lim(int v, int lo, int hi);
        return (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    // gain goes to the front end first; the back end only takes what is left above 7
    function automatic logic [31:0] pack(int k, int m, int e, int g);
        int y;
        y = lim(g, 0, 5'h16);
        case (k)
            0: pack = {3'h0, 4'(y >= 8 ? y - 7 : 0), 3'(y >= 8 ? 7 : y),
                       6'(lim(e, 0, 6'h3F)), 16'(lim(m, 1, 16'hFFFF))};
            1, 2: pack = {10'h000, 5'(lim(e, 0, 5'h1F)),
                          17'(lim(m, 1, 17'h1_FFFF))};
            default: pack = {12'h000, 5'(lim(e, 0, 5'h1F)), 15'(lim(m, 1, 15'h7FFF))};
        endcase
    endfunction
endmodule

`default_nettype wire

// *** tb/lfc_loop_filter_coeff_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module lfc_loop_filter_coeff_test;
    logic clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr, upd_i, valid_o, prof_o, sel;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, last_a, cw[2][4], dsw[2], duv[2];
    logic signed [23:0] err_i;
    logic signed [31:0] at_o, bt_o, gt_o, dt_o, filt_o;
    logic [30:0] div_int_o;
    logic [9:0] div_num_o, div_den_o;
    int err_count, n_checks, nupd, kexp;
    longint integ;

    lfc_loop_filter_coeff dut_u (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .upd_i(upd_i),
        .err_i(err_i), .alpha_term_o(at_o), .beta_term_o(bt_o), .gamma_term_o(gt_o),
        .delta_term_o(dt_o), .filt_o(filt_o), .valid_o(valid_o), .prof_o(prof_o),
        .div_int_o(div_int_o), .div_num_o(div_num_o), .div_den_o(div_den_o));

    lfc_host host_u (.clk_i(clk_i), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata));

    task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
            err_count++;
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    function automatic logic signed [31:0] sat(longint v);
        if (v > 64'sh7FFF_FFFF) return 32'sh7FFF_FFFF;
        if (v < -64'sh8000_0000) return 32'sh8000_0000;
        return 32'(v);
    endfunction

    // 64-bit products keep the largest gain shift from wrapping before saturation
    function automatic logic signed [31:0] exp_term(int k, logic [31:0] w, logic signed [23:0] e);
        longint p;
        case (k)
            // the gain sum is widened: two narrow fields would wrap a total of 22 in four bits
            0: p = ((longint'(e) * longint'(w[15:0])) <<< (int'(w[24:22]) + int'(w[28:25])))
                   >>> (16 + w[21:16]);
            1, 2: p = -((longint'(e) * longint'(w[16:0])) >>> (17 + w[21:17]));
            default: p = (longint'(e) * longint'(w[14:0])) >>> (15 + w[19:15]);
        endcase
        return sat(p);
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        host_u.xfer(1'b1, a, d, r, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
        logic [31:0] r;
        logic e;
        host_u.xfer(1'b0, a, 32'h0000_0000, r, e);
        check("rdata", r, exp);
        check("pslverr", e, eerr);
    endtask

    task automatic update(input logic signed [23:0] e);
        logic signed [31:0] t[4];
        @(posedge clk_i);
        upd_i <= 1'b1;
        err_i <= e;
        @(posedge clk_i);
        upd_i <= 1'b0;
        @(negedge clk_i);
        for (int k = 0; k < 4; k++) t[k] = exp_term(k, cw[sel][k], e);
        integ = sat(integ + t[2]);
        last_a = t[0];
        nupd++;
        check("valid", valid_o, 1'b1);
        check("prof", prof_o, sel);
        check("alpha", at_o, t[0]);
        check("beta", bt_o, t[1]);
        check("gamma", gt_o, t[2]);
        check("delta", dt_o, t[3]);
        check("filt", filt_o, sat(t[0] + t[1] + integ + t[3]));
        @(negedge clk_i);
        check("valid", valid_o, 1'b0);
    endtask

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    initial begin
        repeat (6000) @(posedge clk_i);
        err_count++;
        wrap_up();
    end

    initial begin
        rst_n_i = 1'b0;
        upd_i = 1'b0;
        err_i = 24'h00_0000;
        sel = 1'b0;
        void'($urandom(32'h71d7));
        kexp = $clog2(int'(host_u.scale_k()));
        repeat (4) @(posedge clk_i);
        check("div_int", div_int_o, 31'h1);
        rst_n_i <= 1'b1;
        rdc(8'h00, 32'h0000_0000, 1'b0);
        rdc(8'h5C, 32'h0000_0000, 1'b1);
        rdc(8'h02, 32'h0000_0000, 1'b1);
        for (int r = 0; r < 4; r++) begin
            for (int p = 0; p < 2; p++) begin
                for (int k = 0; k < 4; k++) begin
                    cw[p][k] = host_u.pack(k, $urandom_range(0, 32'h2_0000),
                                           $urandom_range(0, 8'h46), $urandom_range(0, 8'h19));
                    // corners: zero exponents with gain 8, a pure shift of 6, the capped gain
                    if (r == 0 && p == 0) cw[p][k] = host_u.pack(k, cw[p][k][15:0], 0, 8);
                    if (r == 1 && p == 1 && k == 0) cw[p][k] = host_u.pack(0, 16'hD0A8, 6, 0);
                    if (r == 2 && p == 0 && k == 0) cw[p][k] = host_u.pack(0, 16'hFFFF, 0, kexp);
                    if (r == 0 && p == 1 && k == 0) cw[p][k] = host_u.pack(0, 16'hFFFF, 0, 5'h16);
                    wr(8'(p * 32 + k * 4), cw[p][k]);
                end
                dsw[p] = $urandom() & 32'h3FFF_FFFF;
                duv[p] = $urandom() & 32'h000F_FFFF;
                wr(8'(p * 32 + 16), dsw[p]);
                wr(8'(p * 32 + 20), duv[p]);
            end
            rdc(8'h20, cw[1][0], 1'b0);
            sel = r[0];
            integ = 0;
            wr(8'h40, {30'h0, 1'b1, sel});
            @(negedge clk_i);
            @(negedge clk_i);
            check("div_int", div_int_o, 31'(dsw[sel][29:0]) + 31'h1);
            check("div_num", div_num_o, duv[sel][9:0]);
            check("div_den", div_den_o, duv[sel][19:10]);
            for (int i = 0; i < 10; i++) begin
                if (i == 0) update(24'sh7F_FFFF);
                else if (i == 1) update(24'sh80_0000);
                else update(24'($urandom()));
            end
            rdc(8'h48, last_a, 1'b0);
        end
        rdc(8'h44, {16'(nupd), 15'h0000, sel}, 1'b0);
        wrap_up();
    end
endmodule

`default_nettype wire
